// *** core/sbcr_consts.vh ***
// constants for the smart charge request block
`ifndef SBCR_CONSTS_VH
`define SBCR_CONSTS_VH

// register indices, byte address is four times the index
`define SBCR_IDX_SETUP      8'h28
`define SBCR_IDX_TGT_VOLT   8'h3a
`define SBCR_IDX_PRE_VOLT   8'h3c
`define SBCR_IDX_FAST_CUR   8'h3e
`define SBCR_IDX_MAINT_CUR  8'h40
`define SBCR_IDX_PRE_CUR    8'h42
`define SBCR_IDX_PRE_TEMP   8'h44
`define SBCR_IDX_INH_TEMP   8'h46
`define SBCR_IDX_OV_MARGIN  8'h5d
`define SBCR_IDX_IRQ_STAT   8'h60
`define SBCR_IDX_IRQ_MASK   8'h61
`define SBCR_IDX_REQUEST    8'h62
`define SBCR_IDX_STATE      8'h63

// field positions
`define SBCR_BIT_BCAST_MASK 2
`define SBCR_IRQ_OVP        0
`define SBCR_IRQ_PRECHG     1
`define SBCR_IRQ_TERM       2
`define SBCR_IRQ_SENT       3

// reset values
`define SBCR_RST_SETUP      8'h00
`define SBCR_RST_WORD       16'h0000
`define SBCR_RST_TEMP       8'h00

// precharge exit hysteresis, 3 degrees in 0.1 degree steps
`define SBCR_TEMP_HYST      17'h0001e

// broadcast cadence
`define SBCR_PERIOD_S       10
`define SBCR_CLK_HZ         125000000

// bus message addresses and commands
`define SBCR_ADDR_HOST      7'h08
`define SBCR_ADDR_CHARGER   7'h09
`define SBCR_CMD_CURRENT    8'h14
`define SBCR_CMD_VOLTAGE    8'h15
`define SBCR_CMD_ALARM      8'h16

`endif

// *** core/sbcr_tick.v ***
// periodic one-cycle tick for the broadcast cadence
`timescale 1ns/100ps
module sbcr_tick #(
    parameter [31:0] PERIOD_CYCLES = 32'd1250000000
) (
    // clock and reset
    input  wire pclk,
    input  wire presetn,
    // tick output
    output reg  tick_ff
);

    reg  [31:0] cnt_ff;
    wire        wrap;

    assign wrap = (cnt_ff == PERIOD_CYCLES - 32'd1);

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_ff  <= 32'h0000_0000;
            tick_ff <= 1'b0;
        end else begin
            cnt_ff  <= wrap ? 32'h0000_0000 : cnt_ff + 32'd1;
            tick_ff <= wrap;
        end
    end

endmodule

// *** core/sbcr_top.v ***
// charge request selection, alarm broadcasts and apb registers
//
// Behaviour
// - send requested current and voltage to the charger every 10 seconds.
// - refresh sent values from charge state, pack voltage and temperature.
// - requested voltage is the configured millivolt value, forced to zero on demand.
// - pack voltage above target plus margin is overvoltage and suspends charging.
// - requested current is fast, maintenance, precharge or zero only.
// - request fast current while fast charge is permitted.
// - request zero on termination, then maintenance once termination has gone.
// - request precharge when a cell is low or lowest discharge threshold seen.
// - keep precharge until all cells recover and that threshold condition ends.
// - request precharge when pack voltage is below the precharge voltage.
// - request precharge between inhibit low temperature and precharge threshold.
// - allow fast current only at precharge threshold plus 3 degrees or above; the code also allows it below the inhibit temperature.
// - send alarm to host while any status bit 8 to 15 is set.
// - also send alarm to charger while any status bit 12 to 15 is set.
// - repeat alarms every 10 seconds until the alarm bits clear.
// - broadcast mask bit 2 suppresses every broadcast.
//
// Chosen here: the APB interface to the registers.
`timescale 1ns/100ps
`include "sbcr_consts.vh"
module sbcr_top #(
    parameter [31:0] PERIOD_CYCLES = `SBCR_PERIOD_S * `SBCR_CLK_HZ
) (
    // apb slave
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output wire        pready,
    output reg  [31:0] prdata_ff,
    output reg         pslverr_ff,
    // gauge measurements, same clock
    input  wire [15:0] pack_mv,
    input  wire [15:0] min_cell_mv,
    input  wire [15:0] temp_dc,
    input  wire [15:0] battery_status,
    input  wire        lowest_discharge_threshold,
    input  wire        term_active,
    input  wire        discharge_seen,
    input  wire        volt_force_zero,
    // charge request outputs
    output reg  [15:0] req_current_ff,
    output reg  [15:0] req_voltage_ff,
    output reg         ovp_suspend_ff,
    // broadcast message port
    output reg         msg_valid_ff,
    input  wire        msg_ready,
    output reg  [6:0]  msg_addr_ff,
    output reg  [7:0]  msg_cmd_ff,
    output reg  [15:0] msg_data_ff,
    // interrupt
    output wire        irq
);

    // =========================================================
    // functions
    // =========================================================
    function signed [16:0] sx;
        input [15:0] v;
        begin
            sx = {v[15], v};
        end
    endfunction

    function [3:0] first_one;
        input [3:0] v;
        begin
            first_one = v & (~v + 4'h1);
        end
    endfunction

    // =========================================================
    // registers
    // =========================================================
    reg  [7:0]  setup_ff;
    reg  [15:0] tgt_volt_ff;
    reg  [15:0] pre_volt_ff;
    reg  [15:0] fast_cur_ff;
    reg  [15:0] maint_cur_ff;
    reg  [15:0] pre_cur_ff;
    reg  [7:0]  pre_temp_ff;
    reg  [15:0] inh_temp_ff;
    reg  [15:0] ov_margin_ff;
    reg  [3:0]  irq_stat_ff;
    reg  [3:0]  irq_mask_ff;

    wire        wr_en;
    wire        rd_setup;
    wire [9:0]  idx;
    wire        hit;
    reg  [31:0] nxt_rdata;

    assign pready = 1'b1;
    assign idx    = paddr[11:2];
    assign wr_en  = psel & penable & pwrite;
    assign rd_setup = psel & ~penable;

    // =========================================================
    // charge state
    // =========================================================
    reg         pre_volt_hold_ff;
    reg         pre_temp_hold_ff;
    reg         fast_done_ff;
    reg         ovp_prev_ff;
    reg         pre_prev_ff;
    reg         term_prev_ff;

    wire        cell_low;
    wire        cell_ok;
    wire        pack_low;
    wire        temp_in_band;
    wire        temp_fast_ok;
    wire        temp_low;
    wire        precharge;
    wire [16:0] ov_limit;
    wire        ovp_now;
    wire signed [16:0] temp_s;
    wire signed [16:0] pc_s;
    wire signed [16:0] pc_hyst_s;
    wire signed [16:0] inh_s;
    reg  [15:0] nxt_current;
    reg  [1:0]  cur_sel;

    assign temp_s    = sx(temp_dc);
    assign pc_s      = {9'h000, pre_temp_ff};
    assign pc_hyst_s = pc_s + `SBCR_TEMP_HYST;
    assign inh_s     = sx(inh_temp_ff);

    assign cell_low = (min_cell_mv < pre_volt_ff) | lowest_discharge_threshold;
    assign cell_ok  = (min_cell_mv > pre_volt_ff) & ~lowest_discharge_threshold;
    assign pack_low = pack_mv < pre_volt_ff;
    assign temp_low     = temp_s < inh_s;
    assign temp_in_band = ~temp_low & (temp_s < pc_s);
    assign temp_fast_ok = temp_s >= pc_hyst_s;

    assign precharge = cell_low | pre_volt_hold_ff | pack_low
                     | temp_in_band | pre_temp_hold_ff;

    assign ov_limit = {1'b0, tgt_volt_ff} + {1'b0, ov_margin_ff};
    assign ovp_now  = {1'b0, pack_mv} > ov_limit;

    // pick one of four sources, fast by default
    always @* begin
        nxt_current = fast_cur_ff;
        cur_sel     = 2'h0;
        // zero first, then precharge, then maintenance
        if (term_active | ovp_now) begin
            nxt_current = 16'h0000;
            cur_sel     = 2'h3;
        end else if (precharge) begin
            nxt_current = pre_cur_ff;
            cur_sel     = 2'h2;
        end else if (fast_done_ff) begin
            nxt_current = maint_cur_ff;
            cur_sel     = 2'h1;
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pre_volt_hold_ff <= 1'b0;
            pre_temp_hold_ff <= 1'b0;
            fast_done_ff     <= 1'b0;
            req_current_ff   <= 16'h0000;
            req_voltage_ff   <= 16'h0000;
            ovp_suspend_ff   <= 1'b0;
            ovp_prev_ff      <= 1'b0;
            pre_prev_ff      <= 1'b0;
            term_prev_ff     <= 1'b0;
        end else begin
            if (cell_low) begin
                pre_volt_hold_ff <= 1'b1;
            end else if (cell_ok) begin
                pre_volt_hold_ff <= 1'b0;
            end
            if (temp_in_band) begin
                pre_temp_hold_ff <= 1'b1;
            end else if (temp_fast_ok | temp_low) begin
                pre_temp_hold_ff <= 1'b0;
            end
            // remember termination until discharge restarts the cycle
            if (term_active) begin
                fast_done_ff <= 1'b1;
            end else if (discharge_seen) begin
                fast_done_ff <= 1'b0;
            end
            req_current_ff <= nxt_current;
            // configured voltage, forced zero on demand
            req_voltage_ff <= volt_force_zero ? 16'h0000 : tgt_volt_ff;
            ovp_suspend_ff <= ovp_now;
            ovp_prev_ff    <= ovp_now;
            pre_prev_ff    <= precharge;
            term_prev_ff   <= term_active;
        end
    end

    // =========================================================
    // broadcast scheduler
    // =========================================================
    wire        tick;
    wire        bcast_off;
    wire        alarm_host;
    wire        alarm_chg;
    wire [3:0]  pick;
    wire        sent;
    reg  [3:0]  pend_ff;
    reg  [3:0]  nxt_pend;

    sbcr_tick #(
        .PERIOD_CYCLES (PERIOD_CYCLES)
    ) u_tick (
        .pclk    (pclk),
        .presetn (presetn),
        .tick_ff (tick)
    );

    assign bcast_off  = setup_ff[`SBCR_BIT_BCAST_MASK];
    // host alarm from bits 8 to 15
    assign alarm_host = |battery_status[15:8];
    // charger alarm from bits 12 to 15
    assign alarm_chg  = |battery_status[15:12];
    assign pick       = first_one(pend_ff & {alarm_chg, alarm_host, 2'b11});
    assign sent       = msg_valid_ff & msg_ready;

    always @* begin
        nxt_pend = pend_ff & {alarm_chg, alarm_host, 2'b11};
        if (!msg_valid_ff) begin
            nxt_pend = pend_ff & ~pick;
        end
        // queue current and voltage each period
        // alarms queued again each period while bits stay set
        if (tick) begin
            nxt_pend = nxt_pend | {alarm_chg, alarm_host, 2'b11};
        end
        if (bcast_off) begin
            nxt_pend = 4'h0;
        end
    end

    // one message at a time; a stalled receiver holds the rest pending
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pend_ff      <= 4'h0;
            msg_valid_ff <= 1'b0;
            msg_addr_ff  <= 7'h00;
            msg_cmd_ff   <= 8'h00;
            msg_data_ff  <= 16'h0000;
        end else begin
            pend_ff <= nxt_pend;
            if (msg_valid_ff) begin
                if (msg_ready) begin
                    msg_valid_ff <= 1'b0;
                end
            end else if (|pick && !bcast_off) begin
                msg_valid_ff <= 1'b1;
                case (pick)
                    4'h1: begin
                        msg_addr_ff <= `SBCR_ADDR_CHARGER;
                        msg_cmd_ff  <= `SBCR_CMD_CURRENT;
                        msg_data_ff <= req_current_ff;
                    end
                    4'h2: begin
                        msg_addr_ff <= `SBCR_ADDR_CHARGER;
                        msg_cmd_ff  <= `SBCR_CMD_VOLTAGE;
                        msg_data_ff <= req_voltage_ff;
                    end
                    4'h4: begin
                        msg_addr_ff <= `SBCR_ADDR_HOST;
                        msg_cmd_ff  <= `SBCR_CMD_ALARM;
                        msg_data_ff <= battery_status;
                    end
                    default: begin
                        msg_addr_ff <= `SBCR_ADDR_CHARGER;
                        msg_cmd_ff  <= `SBCR_CMD_ALARM;
                        msg_data_ff <= battery_status;
                    end
                endcase
            end
        end
    end

    // =========================================================
    // interrupts
    // =========================================================
    wire [3:0] irq_set;
    wire [3:0] irq_clr;

    assign irq_set = {sent, term_active & ~term_prev_ff,
                      precharge & ~pre_prev_ff, ovp_now & ~ovp_prev_ff};
    assign irq_clr = (wr_en && idx == {2'b00, `SBCR_IDX_IRQ_STAT}) ? pwdata[3:0] : 4'h0;
    assign irq     = |(irq_stat_ff & irq_mask_ff);

    // set wins over a same-cycle clear
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_stat_ff <= 4'h0;
        end else begin
            irq_stat_ff <= (irq_stat_ff & ~irq_clr) | irq_set;
        end
    end

    // =========================================================
    // apb register access
    // =========================================================
    assign hit = (idx == {2'b00, `SBCR_IDX_SETUP})     | (idx == {2'b00, `SBCR_IDX_TGT_VOLT})
               | (idx == {2'b00, `SBCR_IDX_PRE_VOLT})  | (idx == {2'b00, `SBCR_IDX_FAST_CUR})
               | (idx == {2'b00, `SBCR_IDX_MAINT_CUR}) | (idx == {2'b00, `SBCR_IDX_PRE_CUR})
               | (idx == {2'b00, `SBCR_IDX_PRE_TEMP})  | (idx == {2'b00, `SBCR_IDX_INH_TEMP})
               | (idx == {2'b00, `SBCR_IDX_OV_MARGIN}) | (idx == {2'b00, `SBCR_IDX_IRQ_STAT})
               | (idx == {2'b00, `SBCR_IDX_IRQ_MASK})  | (idx == {2'b00, `SBCR_IDX_REQUEST})
               | (idx == {2'b00, `SBCR_IDX_STATE});

    always @* begin
        nxt_rdata = 32'h0000_0000;
        case (idx[7:0])
            `SBCR_IDX_SETUP:     nxt_rdata = {24'h000000, setup_ff};
            `SBCR_IDX_TGT_VOLT:  nxt_rdata = {16'h0000, tgt_volt_ff};
            `SBCR_IDX_PRE_VOLT:  nxt_rdata = {16'h0000, pre_volt_ff};
            `SBCR_IDX_FAST_CUR:  nxt_rdata = {16'h0000, fast_cur_ff};
            `SBCR_IDX_MAINT_CUR: nxt_rdata = {16'h0000, maint_cur_ff};
            `SBCR_IDX_PRE_CUR:   nxt_rdata = {16'h0000, pre_cur_ff};
            `SBCR_IDX_PRE_TEMP:  nxt_rdata = {24'h000000, pre_temp_ff};
            `SBCR_IDX_INH_TEMP:  nxt_rdata = {16'h0000, inh_temp_ff};
            `SBCR_IDX_OV_MARGIN: nxt_rdata = {16'h0000, ov_margin_ff};
            `SBCR_IDX_IRQ_STAT:  nxt_rdata = {28'h0000000, irq_stat_ff};
            `SBCR_IDX_IRQ_MASK:  nxt_rdata = {28'h0000000, irq_mask_ff};
            // higher-level chargers read the live request here
            `SBCR_IDX_REQUEST:   nxt_rdata = {req_voltage_ff, req_current_ff};
            `SBCR_IDX_STATE:     nxt_rdata = {24'h000000, pend_ff, fast_done_ff,
                                              ovp_suspend_ff, cur_sel};
            default:             nxt_rdata = 32'h0000_0000;
        endcase
        if (idx[9:8] != 2'b00) begin
            nxt_rdata = 32'h0000_0000;
        end
    end

    // read data latched in the setup cycle, so the access phase needs no wait
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_ff  <= 32'h0000_0000;
            pslverr_ff <= 1'b0;
        end else if (rd_setup) begin
            prdata_ff  <= nxt_rdata;
            pslverr_ff <= ~hit;
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            setup_ff     <= `SBCR_RST_SETUP;
            tgt_volt_ff  <= `SBCR_RST_WORD;
            pre_volt_ff  <= `SBCR_RST_WORD;
            fast_cur_ff  <= `SBCR_RST_WORD;
            maint_cur_ff <= `SBCR_RST_WORD;
            pre_cur_ff   <= `SBCR_RST_WORD;
            pre_temp_ff  <= `SBCR_RST_TEMP;
            inh_temp_ff  <= `SBCR_RST_WORD;
            ov_margin_ff <= `SBCR_RST_WORD;
            irq_mask_ff  <= 4'h0;
        end else if (wr_en && idx[9:8] == 2'b00) begin
            case (idx[7:0])
                `SBCR_IDX_SETUP:     setup_ff     <= pwdata[7:0];
                `SBCR_IDX_TGT_VOLT:  tgt_volt_ff  <= pwdata[15:0];
                `SBCR_IDX_PRE_VOLT:  pre_volt_ff  <= pwdata[15:0];
                `SBCR_IDX_FAST_CUR:  fast_cur_ff  <= pwdata[15:0];
                `SBCR_IDX_MAINT_CUR: maint_cur_ff <= pwdata[15:0];
                `SBCR_IDX_PRE_CUR:   pre_cur_ff   <= pwdata[15:0];
                // threshold tops out at 12.7 degrees in 0.1 steps
                `SBCR_IDX_PRE_TEMP:  pre_temp_ff  <= {1'b0, pwdata[6:0]};
                `SBCR_IDX_INH_TEMP:  inh_temp_ff  <= pwdata[15:0];
                `SBCR_IDX_OV_MARGIN: ov_margin_ff <= pwdata[15:0];
                `SBCR_IDX_IRQ_MASK:  irq_mask_ff  <= pwdata[3:0];
                default: begin
                end
            endcase
        end
    end

endmodule

// *** dv/sbcr_checker.sv ***
// port-level assertions for the charge request block
`timescale 1ns/100ps
`include "sbcr_consts.vh"
module sbcr_checker (
    // clock and reset
    input logic        pclk,
    input logic        presetn,
    // gauge inputs
    input logic        term_active,
    input logic        volt_force_zero,
    // request outputs
    input logic [15:0] req_current_ff,
    input logic [15:0] req_voltage_ff,
    input logic        ovp_suspend_ff,
    // message port
    input logic        msg_valid_ff,
    input logic        msg_ready,
    input logic [6:0]  msg_addr_ff,
    input logic [7:0]  msg_cmd_ff,
    input logic [15:0] msg_data_ff
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // ==========================================
    // handshake steps
    sequence s_wait; msg_valid_ff && !msg_ready; endsequence
    sequence s_take; msg_valid_ff && msg_ready; endsequence
    sequence s_alarm; msg_valid_ff && msg_cmd_ff == `SBCR_CMD_ALARM; endsequence

    property p_term_zero; term_active |=> req_current_ff == 16'h0000; endproperty
    a_term_zero: assert property (p_term_zero) else $error("current not zero on termination");
    property p_ovp_zero; ovp_suspend_ff |-> req_current_ff == 16'h0000; endproperty
    a_ovp_zero: assert property (p_ovp_zero) else $error("current not zero in overvoltage");
    property p_vzero; volt_force_zero |=> req_voltage_ff == 16'h0000; endproperty
    a_vzero: assert property (p_vzero) else $error("voltage not forced to zero");
    property p_hold;
        s_wait |=> msg_valid_ff && $stable({msg_addr_ff, msg_cmd_ff, msg_data_ff});
    endproperty
    a_hold: assert property (p_hold) else $error("message changed before accept");
    property p_gap; s_take |=> !msg_valid_ff; endproperty
    a_gap: assert property (p_gap) else $error("no idle cycle after accept");
    property p_dest;
        msg_valid_ff |-> (msg_addr_ff == `SBCR_ADDR_CHARGER && msg_cmd_ff inside
            {`SBCR_CMD_CURRENT, `SBCR_CMD_VOLTAGE, `SBCR_CMD_ALARM})
            || (msg_addr_ff == `SBCR_ADDR_HOST && msg_cmd_ff == `SBCR_CMD_ALARM);
    endproperty
    a_dest: assert property (p_dest) else $error("bad message address or command");
    property p_host; s_alarm ##0 msg_addr_ff == `SBCR_ADDR_HOST |-> msg_data_ff[15:8] != 8'h00; endproperty
    a_host: assert property (p_host) else $error("host alarm without status bits");
    property p_chg; s_alarm ##0 msg_addr_ff == `SBCR_ADDR_CHARGER |-> msg_data_ff[15:12] != 4'h0; endproperty
    a_chg: assert property (p_chg) else $error("charger alarm without status bits");
endmodule

bind sbcr_top sbcr_checker u_chk (
    .pclk(pclk), .presetn(presetn), .term_active(term_active), .volt_force_zero(volt_force_zero),
    .req_current_ff(req_current_ff), .req_voltage_ff(req_voltage_ff), .ovp_suspend_ff(ovp_suspend_ff),
    .msg_valid_ff(msg_valid_ff), .msg_ready(msg_ready), .msg_addr_ff(msg_addr_ff),
    .msg_cmd_ff(msg_cmd_ff), .msg_data_ff(msg_data_ff)
);

// *** dv/sbcr_msg_sink.sv ***
// bus receiver model standing in for charger and host
`timescale 1ns/100ps
module sbcr_msg_sink (
    // clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // pacing from the bench
    input  wire logic slow,
    input  wire logic coin,
    // handshake
    output logic      msg_ready
);
    // lower-level charger takes broadcasts, may stall
    always @(posedge pclk or negedge presetn) begin
        if (!presetn)
            msg_ready <= 1'b0;
        else
            msg_ready <= !slow || coin;
    end
endmodule

// *** dv/test_smart_charge_request_logic.sv ***
// self-checking bench for the charge request block
`timescale 1ns/100ps
`include "sbcr_consts.vh"
module test_smart_charge_request_logic;
    localparam int PER = 200;
    localparam logic [15:0] TGT = 16'h3a98, MRG = 16'h01f4, FAST = 16'h03e8;
    localparam logic [15:0] N = 16'h36b0, C = 16'h0e10, T = 16'h00fa, LOW = 16'h0b54;
    // ==========================================
    // signals
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata_ff, rd, v;
    logic        pready, pslverr_ff, er, ovp_suspend_ff, msg_valid_ff, msg_ready, irq;
    logic [15:0] pack_mv = 16'h0, min_cell_mv = 16'h0, temp_dc = 16'h0, battery_status = 16'h0;
    logic        lowest_discharge_threshold = 1'b0, term_active = 1'b0, discharge_seen = 1'b0;
    logic        volt_force_zero = 1'b0, slow = 1'b0, coin = 1'b0;
    logic [15:0] req_current_ff, req_voltage_ff, msg_data_ff;
    logic [6:0]  msg_addr_ff;
    logic [7:0]  msg_cmd_ff;
    logic [30:0] mq[$];
    int          tq[$];
    int          cyc = 0, i, err_total = 0, check_count = 0;
    integer      seed = 32'h03e9c65e;
    logic [7:0]  ridx [9] = '{`SBCR_IDX_SETUP, `SBCR_IDX_TGT_VOLT, `SBCR_IDX_PRE_VOLT, `SBCR_IDX_FAST_CUR,
        `SBCR_IDX_MAINT_CUR, `SBCR_IDX_PRE_CUR, `SBCR_IDX_PRE_TEMP, `SBCR_IDX_INH_TEMP, `SBCR_IDX_OV_MARGIN};
    logic [31:0] rmsk [9] = '{32'hff, 32'hffff, 32'hffff, 32'hffff, 32'hffff, 32'hffff, 32'h7f, 32'hffff, 32'hffff};
    logic [31:0] cfg [9] = '{32'h0, 32'h3a98, 32'h0bb8, 32'h03e8, 32'h0064, 32'h01f4, 32'h64, 32'h0, 32'h01f4};

    sbcr_top #(.PERIOD_CYCLES(PER)) dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata_ff(prdata_ff),
        .pslverr_ff(pslverr_ff), .pack_mv(pack_mv), .min_cell_mv(min_cell_mv), .temp_dc(temp_dc),
        .battery_status(battery_status), .lowest_discharge_threshold(lowest_discharge_threshold),
        .term_active(term_active), .discharge_seen(discharge_seen), .volt_force_zero(volt_force_zero),
        .req_current_ff(req_current_ff), .req_voltage_ff(req_voltage_ff), .ovp_suspend_ff(ovp_suspend_ff),
        .msg_valid_ff(msg_valid_ff), .msg_ready(msg_ready), .msg_addr_ff(msg_addr_ff),
        .msg_cmd_ff(msg_cmd_ff), .msg_data_ff(msg_data_ff), .irq(irq));
    sbcr_msg_sink msg_sink_u (.pclk(pclk), .presetn(presetn), .slow(slow), .coin(coin), .msg_ready(msg_ready));

    always #4 pclk = ~pclk;
    // log accepted messages with their cycle
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        coin <= 1'($random(seed));
        if (msg_valid_ff === 1'b1 && msg_ready === 1'b1) begin
            mq.push_back({msg_addr_ff, msg_cmd_ff, msg_data_ff});
            tq.push_back(cyc);
        end
    end
    // ==========================================
    // tasks
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task tally_and_finish;
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] wd,
                       output logic [31:0] d, output logic e);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {2'b00, idx, 2'b00};
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        d = prdata_ff;
        e = pslverr_ff;
        psel <= 1'b0;
        penable <= 1'b0;
        #1;
    endtask
    // flags are term, lowest threshold, discharge seen, force zero
    task automatic step(input logic [15:0] pk, cl, tp, input logic [3:0] fl, input logic [15:0] ec);
        @(posedge pclk);
        pack_mv <= pk;
        min_cell_mv <= cl;
        temp_dc <= tp;
        {term_active, lowest_discharge_threshold, discharge_seen, volt_force_zero} <= fl;
        repeat (4) @(posedge pclk);
        #1;
        chk("req_current", {16'h0, req_current_ff}, {16'h0, ec});
        chk("ovp_suspend", {31'h0, ovp_suspend_ff}, {31'h0, pk > TGT + MRG});
        chk("req_voltage", {16'h0, req_voltage_ff}, fl[0] ? 32'h0 : {16'h0, TGT});
    endtask
    function automatic logic [30:0] exp_msg(input int k, input logic [15:0] st);
        if (k == 0) return {`SBCR_ADDR_CHARGER, `SBCR_CMD_CURRENT, FAST};
        if (k == 1) return {`SBCR_ADDR_CHARGER, `SBCR_CMD_VOLTAGE, TGT};
        if (k == 2 && |st[15:8]) return {`SBCR_ADDR_HOST, `SBCR_CMD_ALARM, st};
        return {`SBCR_ADDR_CHARGER, `SBCR_CMD_ALARM, st};
    endfunction
    task automatic bcast(input logic [15:0] st);
        int n, k;
        apb(1'b1, `SBCR_IDX_SETUP, 32'h4, rd, er);
        repeat (30) @(posedge pclk);
        battery_status <= st;
        mq.delete();
        tq.delete();
        apb(1'b1, `SBCR_IDX_SETUP, 32'h0, rd, er);
        n = 2 + int'(|st[15:8]) + int'(|st[15:12]);
        repeat (2 * PER + 80) @(posedge pclk);
        chk("msg_repeat", {31'h0, mq.size() > n}, 32'h1);
        for (k = 0; k <= n && k < mq.size(); k++)
            chk("msg_word", {1'b0, mq[k]}, {1'b0, exp_msg(k % n, st)});
        if (mq.size() > n)
            chk("msg_period", {31'h0, tq[n] - tq[0] inside {[PER - 20:PER + 20]}}, 32'h1);
    endtask
    // ==========================================
    // sequence
    initial begin
        #(8 * 20000);
        err_total++;
        tally_and_finish;
    end
    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        for (i = 0; i < 9; i++) begin
            apb(1'b0, ridx[i], 32'h0, rd, er);
            chk("reg_reset", rd, 32'h0);
            v = $random(seed);
            apb(1'b1, ridx[i], v, rd, er);
            apb(1'b0, ridx[i], 32'h0, rd, er);
            chk("reg_readback", rd, v & rmsk[i]);
            apb(1'b1, ridx[i], cfg[i], rd, er);
        end
        apb(1'b0, 8'h30, 32'h0, rd, er);
        chk("unmapped_err", {31'h0, er}, 32'h1);
        chk("unmapped_data", rd, 32'h0);
        apb(1'b1, `SBCR_IDX_REQUEST, 32'hffffffff, rd, er);
        chk("ro_write_err", {31'h0, er}, 32'h0);
        step(N, C, T, 4'b0000, FAST);
        step(N, LOW, T, 4'b1000, 16'h0);
        step(N, C, T, 4'b0000, 16'h0064);
        step(N, C, T, 4'b0010, FAST);
        step(N, C, T, 4'b0100, 16'h01f4);
        step(N, LOW, T, 4'b0000, 16'h01f4);
        step(N, C, T, 4'b0000, FAST);
        step(16'h0b54, C, T, 4'b0000, 16'h01f4);
        step(N, C, 16'h0032, 4'b0000, 16'h01f4);
        step(N, C, 16'h0081, 4'b0000, 16'h01f4);
        step(N, C, 16'h0082, 4'b0000, FAST);
        step(16'h3c8d, C, T, 4'b0000, 16'h0);
        step(16'h3c8c, C, T, 4'b0000, FAST);
        step(N, C, T, 4'b0001, FAST);
        step(N, C, T, 4'b0000, FAST);
        apb(1'b0, `SBCR_IDX_REQUEST, 32'h0, rd, er);
        chk("request_read", rd, {TGT, FAST});
        slow <= 1'b1;
        bcast(16'hf000);
        bcast(16'h0100);
        bcast(16'h1000);
        bcast(16'h0000);
        apb(1'b1, `SBCR_IDX_SETUP, 32'h4, rd, er);
        repeat (30) @(posedge pclk);
        mq.delete();
        repeat (2 * PER) @(posedge pclk);
        chk("masked_msgs", mq.size(), 32'h0);
        apb(1'b0, `SBCR_IDX_IRQ_STAT, 32'h0, rd, er);
        chk("irq_stat_all", rd, 32'hf);
        apb(1'b1, `SBCR_IDX_IRQ_STAT, 32'hf, rd, er);
        apb(1'b0, `SBCR_IDX_IRQ_STAT, 32'h0, rd, er);
        chk("irq_stat_clear", rd, 32'h0);
        step(N, C, T, 4'b1000, 16'h0);
        apb(1'b0, `SBCR_IDX_IRQ_STAT, 32'h0, rd, er);
        chk("irq_stat_term", rd, 32'h4);
        chk("irq_masked", {31'h0, irq}, 32'h0);
        apb(1'b1, `SBCR_IDX_IRQ_MASK, 32'h4, rd, er);
        chk("irq_raised", {31'h0, irq}, 32'h1);
        apb(1'b1, `SBCR_IDX_IRQ_STAT, 32'h4, rd, er);
        chk("irq_cleared", {31'h0, irq}, 32'h0);
        step(N, C, T, 4'b0010, FAST);
        tally_and_finish;
    end
endmodule
